// ### rtl/xbc_crossbar.v
// Crossbar enable registers and priority pin allocator for ports 0..3.
// Assumes the SFR bus, peripherals and pins are synchronous to SYS_CLK_I.
`timescale 1ns/10ps
`include "xbc_defs.vh"

module xbc_crossbar
(
	// Clock and reset
	input wire SYS_CLK_I,
	input wire NRST_I,
	// SFR bus
	input wire [7:0] SFR_ADDR_I,
	input wire [7:0] SFR_PAGE_I,
	input wire SFR_WR_I,
	input wire SFR_RD_I,
	input wire [7:0] SFR_WDATA_I,
	output reg [7:0] SFR_RDATA_O,
	// Port configuration from other blocks
	input wire CROSSBAR_GLOBAL_ENABLE_I,
	input wire SPI_FOUR_WIRE_I,
	input wire [`XBC_NANA-1:0] PIN_ANALOG_I,
	input wire [`XBC_NPIN-1:0] PORT_LATCH_I,
	input wire [`XBC_NPIN-1:0] PORT_PUSH_PULL_I,
	// Peripheral outputs
	input wire UART_A_TX_I,
	input wire SPI_SCK_I,
	input wire SPI_SCK_DRV_I,
	input wire SPI_MISO_I,
	input wire SPI_MISO_DRV_I,
	input wire SPI_MOSI_I,
	input wire SPI_MOSI_DRV_I,
	input wire SPI_NSS_I,
	input wire SPI_NSS_DRV_I,
	input wire SMB_SDA_LOW_I,
	input wire SMB_SCL_LOW_I,
	input wire [5:0] CAPTURE_OUT_I,
	input wire CMP0_OUT_I,
	input wire CMP1_OUT_I,
	// Peripheral inputs, idle high when not routed
	output wire UART_A_RX_O,
	output wire SPI_SCK_O,
	output wire SPI_MISO_O,
	output wire SPI_MOSI_O,
	output wire SPI_NSS_O,
	output wire SMB_SDA_O,
	output wire SMB_SCL_O,
	output wire COUNTER_EXT_IN_O,
	output wire TIMER0_COUNT_IN_O,
	output wire EXT_IRQ0_N_O,
	output wire TIMER1_COUNT_IN_O,
	output wire EXT_IRQ1_N_O,
	output wire TIMER2_COUNT_IN_O,
	output wire TIMER2_CAPTURE_IN_O,
	// Pins of ports 0..3, bit 8*n+k is Pn.k
	input wire [`XBC_NPIN-1:0] PIN_I,
	output wire [`XBC_NPIN-1:0] PIN_O,
	output wire [`XBC_NPIN-1:0] PIN_OE_N_O
);

	reg [7:0] crossbar_enable_a_reg;
	reg [7:0] crossbar_enable_b_reg;
	reg [`XBC_NSLOT-1:0] slot_en;
	reg [`XBC_NSLOT-1:0] sig_out;
	reg [`XBC_NSLOT-1:0] sig_drv;
	reg [`XBC_NSLOT-1:0] sig_in_reg;
	reg [`XBC_NSLOT-1:0] sig_in_next;
	reg [`XBC_NPIN-1:0] sel_vld;
	reg [5*`XBC_NPIN-1:0] sel_idx;
	reg [`XBC_NPIN-1:0] pin_skip;
	wire [`XBC_NPIN-1:0] map_vld;
	wire [5*`XBC_NPIN-1:0] map_idx;
	wire [2:0] cap_sel;
	reg [2:0] cap_cnt;
	reg [5:0] rank;
	reg [5:0] pos;
	// Each process owns its loop index, so no variable has two drivers
	integer p_alloc;
	integer p_fb;
	integer s_en;
	integer s_out;
	integer s_alloc;

	// Number of capture outputs selected; the reserved code selects none
	function [2:0] xbc_cap_count;
		input [2:0] code;
		begin
			if (code > `XBC_CAP_MAX)
				xbc_cap_count = 3'h0;
			else
				xbc_cap_count = code;
		end
	endfunction

	// Register select; only the crossbar page reaches these addresses
	function xbc_sel;
		input [7:0] page;
		input [7:0] addr;
		input [7:0] target;
		begin
			xbc_sel = (page == `XBC_SFR_PAGE) && (addr == target);
		end
	endfunction

	// Enable registers, written by software during setup
	always @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			crossbar_enable_a_reg <= `XBC_RST_ENABLE_A;
			crossbar_enable_b_reg <= `XBC_RST_ENABLE_B;
		end
		else if (SFR_WR_I)
		begin
			if (xbc_sel(SFR_PAGE_I, SFR_ADDR_I, `XBC_ADDR_ENABLE_A))
				crossbar_enable_a_reg <= SFR_WDATA_I;
			if (xbc_sel(SFR_PAGE_I, SFR_ADDR_I, `XBC_ADDR_ENABLE_B))
				crossbar_enable_b_reg <= SFR_WDATA_I;
		end
	end

	// Registered read data; unmapped addresses read as zero
	always @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			SFR_RDATA_O <= `XBC_RDATA_IDLE;
		else if (SFR_RD_I && xbc_sel(SFR_PAGE_I, SFR_ADDR_I, `XBC_ADDR_ENABLE_A))
			SFR_RDATA_O <= crossbar_enable_a_reg;
		else if (SFR_RD_I && xbc_sel(SFR_PAGE_I, SFR_ADDR_I, `XBC_ADDR_ENABLE_B))
			SFR_RDATA_O <= crossbar_enable_b_reg;
		else
			SFR_RDATA_O <= `XBC_RDATA_IDLE;
	end

	assign cap_sel = crossbar_enable_a_reg[`XBC_A_CAP_HI:`XBC_A_CAP_LO];

	// Which slots claim a pin, in priority order
	always @*
	begin
		slot_en = {`XBC_NSLOT{1'b0}};
		cap_cnt = xbc_cap_count(cap_sel);
		slot_en[`XBC_S_TX] = crossbar_enable_a_reg[`XBC_A_UART];
		slot_en[`XBC_S_RX] = crossbar_enable_a_reg[`XBC_A_UART];
		slot_en[`XBC_S_SCK] = crossbar_enable_a_reg[`XBC_A_SPI];
		slot_en[`XBC_S_MISO] = crossbar_enable_a_reg[`XBC_A_SPI];
		slot_en[`XBC_S_MOSI] = crossbar_enable_a_reg[`XBC_A_SPI];
		slot_en[`XBC_S_NSS] = crossbar_enable_a_reg[`XBC_A_SPI] & SPI_FOUR_WIRE_I;
		slot_en[`XBC_S_SDA] = crossbar_enable_a_reg[`XBC_A_SMB];
		slot_en[`XBC_S_SCL] = crossbar_enable_a_reg[`XBC_A_SMB];
		for (s_en = 0; s_en < 6; s_en = s_en + 1)
			slot_en[`XBC_S_CAP0 + s_en] = (s_en < cap_cnt);
		slot_en[`XBC_S_ECI] = crossbar_enable_a_reg[`XBC_A_ECI];
		slot_en[`XBC_S_CMP0] = crossbar_enable_a_reg[`XBC_A_CMP0];
		slot_en[`XBC_S_CMP1] = crossbar_enable_b_reg[`XBC_B_CMP1];
		slot_en[`XBC_S_T0] = crossbar_enable_b_reg[`XBC_B_T0];
		slot_en[`XBC_S_IRQ0] = crossbar_enable_b_reg[`XBC_B_IRQ0];
		slot_en[`XBC_S_T1] = crossbar_enable_b_reg[`XBC_B_T1];
		slot_en[`XBC_S_IRQ1] = crossbar_enable_b_reg[`XBC_B_IRQ1];
		slot_en[`XBC_S_T2] = crossbar_enable_b_reg[`XBC_B_T2];
		slot_en[`XBC_S_TIMER2_CAPTURE_IN] = crossbar_enable_b_reg[`XBC_B_TIMER2_CAPTURE_IN];
		slot_en[`XBC_S_CLK] = crossbar_enable_b_reg[`XBC_B_SYSCK];
	end

	// Outputs each slot offers the pin; input-only slots never drive
	always @*
	begin
		sig_out = {`XBC_NSLOT{1'b1}};
		sig_drv = {`XBC_NSLOT{1'b0}};
		sig_out[`XBC_S_TX] = UART_A_TX_I;
		sig_drv[`XBC_S_TX] = 1'b1;
		sig_out[`XBC_S_SCK] = SPI_SCK_I;
		sig_drv[`XBC_S_SCK] = SPI_SCK_DRV_I;
		sig_out[`XBC_S_MISO] = SPI_MISO_I;
		sig_drv[`XBC_S_MISO] = SPI_MISO_DRV_I;
		sig_out[`XBC_S_MOSI] = SPI_MOSI_I;
		sig_drv[`XBC_S_MOSI] = SPI_MOSI_DRV_I;
		sig_out[`XBC_S_NSS] = SPI_NSS_I;
		sig_drv[`XBC_S_NSS] = SPI_NSS_DRV_I;
		// SMBus lines are open drain: only ever pulled low
		sig_out[`XBC_S_SDA] = 1'b0;
		sig_drv[`XBC_S_SDA] = SMB_SDA_LOW_I;
		sig_out[`XBC_S_SCL] = 1'b0;
		sig_drv[`XBC_S_SCL] = SMB_SCL_LOW_I;
		for (s_out = 0; s_out < 6; s_out = s_out + 1)
		begin
			sig_out[`XBC_S_CAP0 + s_out] = CAPTURE_OUT_I[s_out];
			sig_drv[`XBC_S_CAP0 + s_out] = 1'b1;
		end
		sig_out[`XBC_S_CMP0] = CMP0_OUT_I;
		sig_drv[`XBC_S_CMP0] = 1'b1;
		sig_out[`XBC_S_CMP1] = CMP1_OUT_I;
		sig_drv[`XBC_S_CMP1] = 1'b1;
		sig_drv[`XBC_S_CLK] = 1'b1;
	end

	// Pins in analog mode are passed over by the allocator
	always @*
	begin
		pin_skip = {`XBC_NPIN{1'b0}};
		pin_skip[`XBC_ANA_LO +: `XBC_NANA] = PIN_ANALOG_I;
	end

	// Nth enabled slot lands on the Nth non-skipped pin
	always @*
	begin
		sel_vld = {`XBC_NPIN{1'b0}};
		sel_idx = {5*`XBC_NPIN{1'b0}};
		rank = 6'h00;
		pos = 6'h00;
		for (p_alloc = 0; p_alloc < `XBC_NPIN; p_alloc = p_alloc + 1)
		begin
			if (!pin_skip[p_alloc])
			begin
				pos = 6'h00;
				for (s_alloc = 0; s_alloc < `XBC_NSLOT; s_alloc = s_alloc + 1)
				begin
					if (slot_en[s_alloc])
					begin
						if (pos == rank)
						begin
							sel_vld[p_alloc] = 1'b1;
							sel_idx[5*p_alloc +: 5] = s_alloc[4:0];
						end
						pos = pos + 6'h01;
					end
				end
				rank = rank + 6'h01;
			end
		end
	end

	// One registered slot per pin; port outputs stay off until global enable
	genvar g;
	generate
		for (g = 0; g < `XBC_NPIN; g = g + 1)
		begin : g_pin
			xbc_pin_slot u_slot
			(
				.clk_i(SYS_CLK_I),
				.nrst_i(NRST_I),
				.sel_vld_i(sel_vld[g]),
				.sel_idx_i(sel_idx[5*g +: 5]),
				.sig_out_i(sig_out),
				.sig_drv_i(sig_drv),
				.latch_i(PORT_LATCH_I[g]),
				.push_pull_i(PORT_PUSH_PULL_I[g]),
				.xbar_en_i(CROSSBAR_GLOBAL_ENABLE_I),
				.pin_o(PIN_O[g]),
				.pin_oe_n_o(PIN_OE_N_O[g]),
				.vld_o(map_vld[g]),
				.idx_o(map_idx[5*g +: 5])
			);
		end
	endgenerate

	// Feed pin levels back to the slot that owns the pin; unrouted reads high
	always @*
	begin
		sig_in_next = {`XBC_NSLOT{1'b1}};
		for (p_fb = 0; p_fb < `XBC_NPIN; p_fb = p_fb + 1)
		begin
			if (map_vld[p_fb])
				sig_in_next[map_idx[5*p_fb +: 5]] = PIN_I[p_fb];
		end
	end

	// Registered so peripherals never see a mid-reassignment glitch
	always @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			sig_in_reg <= {`XBC_NSLOT{1'b1}};
		else
			sig_in_reg <= sig_in_next;
	end

	assign UART_A_RX_O = sig_in_reg[`XBC_S_RX];
	assign SPI_SCK_O = sig_in_reg[`XBC_S_SCK];
	assign SPI_MISO_O = sig_in_reg[`XBC_S_MISO];
	assign SPI_MOSI_O = sig_in_reg[`XBC_S_MOSI];
	assign SPI_NSS_O = sig_in_reg[`XBC_S_NSS];
	assign SMB_SDA_O = sig_in_reg[`XBC_S_SDA];
	assign SMB_SCL_O = sig_in_reg[`XBC_S_SCL];
	assign COUNTER_EXT_IN_O = sig_in_reg[`XBC_S_ECI];
	assign TIMER0_COUNT_IN_O = sig_in_reg[`XBC_S_T0];
	assign EXT_IRQ0_N_O = sig_in_reg[`XBC_S_IRQ0];
	assign TIMER1_COUNT_IN_O = sig_in_reg[`XBC_S_T1];
	assign EXT_IRQ1_N_O = sig_in_reg[`XBC_S_IRQ1];
	assign TIMER2_COUNT_IN_O = sig_in_reg[`XBC_S_T2];
	assign TIMER2_CAPTURE_IN_O = sig_in_reg[`XBC_S_TIMER2_CAPTURE_IN];

endmodule // xbc_crossbar

// ### inc/xbc_defs.vh
// Constants for the port crossbar enable registers and pin allocator.
// Assumes an 8-bit special-function-register bus with paged addressing.
`ifndef XBC_DEFS_VH
`define XBC_DEFS_VH

// Register addresses and page
`define XBC_ADDR_ENABLE_A 8'he1
`define XBC_ADDR_ENABLE_B 8'he2
`define XBC_SFR_PAGE 8'h0f
`define XBC_RST_ENABLE_A 8'h00
`define XBC_RST_ENABLE_B 8'h00
`define XBC_RDATA_IDLE 8'h00

// Fields of crossbar_enable_a
`define XBC_A_CMP0 7
`define XBC_A_ECI 6
`define XBC_A_CAP_HI 5
`define XBC_A_CAP_LO 3
`define XBC_A_UART 2
`define XBC_A_SPI 1
`define XBC_A_SMB 0
`define XBC_CAP_MAX 3'h6

// Fields of crossbar_enable_b
`define XBC_B_SYSCK 7
`define XBC_B_TIMER2_CAPTURE_IN 6
`define XBC_B_T2 5
`define XBC_B_IRQ1 4
`define XBC_B_T1 3
`define XBC_B_IRQ0 2
`define XBC_B_T0 1
`define XBC_B_CMP1 0

// Signal slots in crossbar priority order
`define XBC_NSLOT 24
`define XBC_S_TX 0
`define XBC_S_RX 1
`define XBC_S_SCK 2
`define XBC_S_MISO 3
`define XBC_S_MOSI 4
`define XBC_S_NSS 5
`define XBC_S_SDA 6
`define XBC_S_SCL 7
`define XBC_S_CAP0 8
`define XBC_S_ECI 14
`define XBC_S_CMP0 15
`define XBC_S_CMP1 16
`define XBC_S_T0 17
`define XBC_S_IRQ0 18
`define XBC_S_T1 19
`define XBC_S_IRQ1 20
`define XBC_S_T2 21
`define XBC_S_TIMER2_CAPTURE_IN 22
`define XBC_S_CLK 23

// Pins: ports 0..3, eight pins each; ports 1 and 2 may be analog
`define XBC_NPIN 32
`define XBC_ANA_LO 8
`define XBC_NANA 16

`endif

// ### rtl/xbc_pin_slot.v
// One crossbar pin: holds its signal assignment and registered drive state.
// Assumes selection inputs are settled combinational values in SYS_CLK domain.
`timescale 1ns/10ps
`include "xbc_defs.vh"

module xbc_pin_slot
(
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Assignment chosen by the allocator
	input wire sel_vld_i,
	input wire [4:0] sel_idx_i,
	// Peripheral side, one bit per slot
	input wire [`XBC_NSLOT-1:0] sig_out_i,
	input wire [`XBC_NSLOT-1:0] sig_drv_i,
	// Port side controls
	input wire latch_i,
	input wire push_pull_i,
	input wire xbar_en_i,
	// Pin
	output wire pin_o,
	output wire pin_oe_n_o,
	output wire vld_o,
	output wire [4:0] idx_o
);

	reg vld_reg;
	reg [4:0] idx_reg;
	reg val_reg;
	reg drv_reg;
	reg val_next;
	reg drv_next;

	// Value and drive request for the pin, peripheral or port latch
	always @*
	begin
		if (sel_vld_i)
		begin
			val_next = sig_out_i[sel_idx_i];
			drv_next = sig_drv_i[sel_idx_i] & (~sig_out_i[sel_idx_i] | push_pull_i);
			if (sel_idx_i == `XBC_S_CLK)
				drv_next = 1'b1;
		end
		else
		begin
			val_next = latch_i;
			drv_next = ~latch_i | push_pull_i;
		end
	end

	// Drivers held off until the crossbar is globally enabled
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			vld_reg <= 1'b0;
			idx_reg <= 5'h00;
			val_reg <= 1'b1;
			drv_reg <= 1'b0;
		end
		else
		begin
			vld_reg <= sel_vld_i;
			idx_reg <= sel_idx_i;
			val_reg <= val_next;
			drv_reg <= drv_next & xbar_en_i;
		end
	end

	// The clock slot bypasses the flop: a sampled clock cannot carry itself
	assign pin_o = (vld_reg && idx_reg == `XBC_S_CLK) ? ~clk_i : val_reg;
	assign pin_oe_n_o = ~drv_reg;
	assign vld_o = vld_reg;
	assign idx_o = idx_reg;

endmodule // xbc_pin_slot

// ### dv/xbc_crossbar_properties.sv
// Checker for the crossbar enable registers, pin map and driver gating.
// Assumes it is bound to xbc_crossbar and sees only its ports.
`timescale 1ns/10ps
module xbc_crossbar_chk
(
	// Clock, reset and register bus
	input wire SYS_CLK_I,
	input wire NRST_I,
	input wire [7:0] SFR_ADDR_I,
	input wire [7:0] SFR_PAGE_I,
	input wire SFR_WR_I,
	input wire SFR_RD_I,
	input wire [7:0] SFR_WDATA_I,
	input wire [7:0] SFR_RDATA_O,
	// Pins and peripheral signals
	input wire CROSSBAR_GLOBAL_ENABLE_I,
	input wire UART_A_TX_I,
	input wire CMP0_OUT_I,
	input wire CMP1_OUT_I,
	input wire UART_A_RX_O,
	input wire [31:0] PORT_LATCH_I,
	input wire [31:0] PIN_I,
	input wire [31:0] PIN_O,
	input wire [31:0] PIN_OE_N_O
);
	reg [7:0] ena_reg;
	reg [7:0] enb_reg;
	wire wr_ok = SFR_WR_I && SFR_PAGE_I == 8'h0f;
	wire reg_adr = SFR_ADDR_I == 8'he1 || SFR_ADDR_I == 8'he2;
	// Shadow copies of both enables, so the pin map can be predicted
	always @(posedge SYS_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			ena_reg <= 8'h00;
			enb_reg <= 8'h00;
		end
		else if (wr_ok && SFR_ADDR_I == 8'he1)
			ena_reg <= SFR_WDATA_I;
		else if (wr_ok && SFR_ADDR_I == 8'he2)
			enb_reg <= SFR_WDATA_I;
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);
	// Map follows the enables one cycle late, so the pin checks look one cycle back and the RX checks two
	read_back_a: assert property (wr_ok && reg_adr ##1 SFR_RD_I && SFR_PAGE_I == 8'h0f && $stable(SFR_ADDR_I)
		|=> SFR_RDATA_O == $past(SFR_WDATA_I, 2)) else $error("read back differs");
	drv_off_a: assert property (!CROSSBAR_GLOBAL_ENABLE_I |=> &PIN_OE_N_O) else $error("pin driven while off");
	tx_route_a: assert property ($past(ena_reg[2]) |-> PIN_O[0] == $past(UART_A_TX_I)) else $error("tx pin");
	rx_route_a: assert property ($past(ena_reg[2], 2) && $past(ena_reg[2])
		|-> UART_A_RX_O == $past(PIN_I[1]) && PIN_OE_N_O[1]) else $error("rx pin");
	rx_idle_a: assert property (!$past(ena_reg[2], 2) && !$past(ena_reg[2]) |-> UART_A_RX_O) else $error("rx idle");
	cap_none_a: assert property (($past(ena_reg) == 8'h38 || $past(ena_reg) == 8'h00) && $past(enb_reg) == 8'h00
		|-> PIN_O == $past(PORT_LATCH_I)) else $error("pin taken");
	cmp0_pin_a: assert property ($past(ena_reg) == 8'h80 && $past(enb_reg) == 8'h00
		|-> PIN_O[0] == $past(CMP0_OUT_I)) else $error("cmp0 pin");
	cmp1_pin_a: assert property ($past(ena_reg) == 8'h00 && $past(enb_reg) == 8'h01
		|-> PIN_O[0] == $past(CMP1_OUT_I)) else $error("cmp1 pin");
	clk_pin_a: assert property ($past(ena_reg) == 8'h00 && $past(enb_reg) == 8'h80 && $past(CROSSBAR_GLOBAL_ENABLE_I)
		|-> PIN_O[0] && !PIN_OE_N_O[0]) else $error("clock pin");
	// Main scenarios
	cover property (ena_reg == 8'h35 && enb_reg == 8'h14);
	cover property (!CROSSBAR_GLOBAL_ENABLE_I ##1 CROSSBAR_GLOBAL_ENABLE_I);
	cover property (ena_reg == 8'h38);
endmodule // xbc_crossbar_chk

bind xbc_crossbar xbc_crossbar_chk chk
(
	.SYS_CLK_I(SYS_CLK_I),
	.NRST_I(NRST_I),
	.SFR_ADDR_I(SFR_ADDR_I),
	.SFR_PAGE_I(SFR_PAGE_I),
	.SFR_WR_I(SFR_WR_I),
	.SFR_RD_I(SFR_RD_I),
	.SFR_WDATA_I(SFR_WDATA_I),
	.SFR_RDATA_O(SFR_RDATA_O),
	.CROSSBAR_GLOBAL_ENABLE_I(CROSSBAR_GLOBAL_ENABLE_I),
	.UART_A_TX_I(UART_A_TX_I),
	.CMP0_OUT_I(CMP0_OUT_I),
	.CMP1_OUT_I(CMP1_OUT_I),
	.UART_A_RX_O(UART_A_RX_O),
	.PORT_LATCH_I(PORT_LATCH_I),
	.PIN_I(PIN_I),
	.PIN_O(PIN_O),
	.PIN_OE_N_O(PIN_OE_N_O)
);

// ### dv/tb_xbc_crossbar.sv
// Self-checking bench for the crossbar enable registers and pin allocator.
// Assumes one 40 MHz clock; the checker is bound from its own file.
`timescale 1ns/10ps
module tb_xbc_crossbar;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, gen = 1, four = 0, sdrv = 0;
	logic tx = 1, sda = 0, scl = 0, cmp0 = 0, cmp1 = 0;
	logic [7:0] addr = 0, page = 8'h0f, wdata = 0;
	logic [5:0] cap = 0;
	logic [15:0] ana = 0;
	logic [31:0] latch = '1, pp = '1, pin = '1;
	wire [7:0] rdata;
	wire [31:0] pin_o, oe_n;
	wire rx, eci, t0, t1, t2, t2x, i0, i1;
	wire sck_in, miso_in, mosi_in, nss_in, sda_in, scl_in;
	int mismatches = 0, checks_done = 0;
	// SPI values and drive requests share one low source: SPI never drives here
	xbc_crossbar dut
	(
		.SYS_CLK_I(clk), .NRST_I(nrst), .SFR_ADDR_I(addr), .SFR_PAGE_I(page), .SFR_WR_I(wr), .SFR_RD_I(rd),
		.SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .CROSSBAR_GLOBAL_ENABLE_I(gen), .SPI_FOUR_WIRE_I(four),
		.PIN_ANALOG_I(ana), .PORT_LATCH_I(latch), .PORT_PUSH_PULL_I(pp), .UART_A_TX_I(tx),
		.SPI_SCK_I(sdrv), .SPI_SCK_DRV_I(sdrv), .SPI_MISO_I(sdrv), .SPI_MISO_DRV_I(sdrv),
		.SPI_MOSI_I(sdrv), .SPI_MOSI_DRV_I(sdrv), .SPI_NSS_I(sdrv), .SPI_NSS_DRV_I(sdrv),
		.SMB_SDA_LOW_I(sda), .SMB_SCL_LOW_I(scl), .CAPTURE_OUT_I(cap), .CMP0_OUT_I(cmp0), .CMP1_OUT_I(cmp1),
		.UART_A_RX_O(rx), .SPI_SCK_O(sck_in), .SPI_MISO_O(miso_in), .SPI_MOSI_O(mosi_in),
		.SPI_NSS_O(nss_in), .SMB_SDA_O(sda_in), .SMB_SCL_O(scl_in),
		.COUNTER_EXT_IN_O(eci), .TIMER0_COUNT_IN_O(t0), .EXT_IRQ0_N_O(i0), .TIMER1_COUNT_IN_O(t1),
		.EXT_IRQ1_N_O(i1), .TIMER2_COUNT_IN_O(t2), .TIMER2_CAPTURE_IN_O(t2x),
		.PIN_I(pin), .PIN_O(pin_o), .PIN_OE_N_O(oe_n)
	);
	always #12.5 clk = ~clk;
	// Step past edges; inputs always change 1 ns after the edge
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Idle cycle after the strobe so back-to-back calls never retoggle it at once
	task wr8(input [7:0] a, input [7:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		cyc(1);
		wr = 0;
		cyc(1);
	endtask
	task rd8(input [7:0] a, input [7:0] e);
		addr = a;
		rd = 1;
		cyc(1);
		chk(rdata, e);
		rd = 0;
		cyc(1);
	endtask
	// Mapping settles one cycle after the write, inputs two; four leaves margin for inputs
	task cfg(input [7:0] a, input [7:0] b);
		wr8(8'he1, a);
		wr8(8'he2, b);
		cyc(4);
	endtask
	task t_regs;
		rd8(8'he1, 8'h00);
		rd8(8'he2, 8'h00);
		page = 8'h00;
		wr8(8'he1, 8'hff);
		page = 8'h0f;
		wr8(8'he3, 8'hff);
		rd8(8'he1, 8'h00);
		rd8(8'he3, 8'h00);
		addr = 8'he2;
		wdata = 8'h5a;
		wr = 1;
		cyc(1);
		wr = 0;
		rd = 1;
		cyc(1);
		chk(rdata, 8'h5a);
		rd = 0;
		cyc(1);
	endtask
	task t_codes;
		for (int c = 0; c < 8; c++)
		begin
			cfg(8'(c * 8), 8'h00);
			chk(pin_o[5:0], c == 7 ? 32'h3f : 32'h3f & (32'h3f << c));
		end
	endtask
	task t_example;
		ana = 16'h001c;
		cap = 6'h2a;
		tx = 0;
		sda = 1;
		pin = 32'hffff_dffd;
		// Capture code 110 with UART and SMBus; 111 would be the reserved code
		cfg(8'h35, 8'h14);
		chk({pin_o[9:4], pin_o[2], pin_o[0], oe_n[2:1]}, {cap, 4'b0001});
		chk({rx, i0, i1}, 3'b001);
		gen = 0;
		cyc(2);
		chk(oe_n, 32'hffff_ffff);
		chk(i0, 0);
		gen = 1;
		{ana, cap, tx, sda, pin} = {16'h0, 6'h0, 1'b1, 1'b0, 32'hffff_ffff};
	endtask
	task t_inputs;
		pin = 32'hffff_fffe;
		for (int i = 0; i < 7; i++)
		begin
			cfg(i == 6 ? 8'h40 : 8'h00, i == 6 ? 8'h00 : 8'(2 << i));
			chk({eci, t2x, t2, i1, t1, i0, t0}, 7'h7f ^ 7'(1 << i));
		end
		pin = '1;
	endtask
	// Latch held low so a routed high comparator cannot pass for an idle pin
	task t_outs;
		{latch, cmp0, cmp1} = {32'h0, 2'b11};
		cfg(8'h80, 8'h00);
		chk(pin_o[0], 1);
		cfg(8'h00, 8'h01);
		chk(pin_o[0], 1);
		cfg(8'h00, 8'h00);
		chk(pin_o[0], 0);
		cfg(8'h00, 8'h80);
		@(negedge clk);
		#1;
		chk({pin_o[0], oe_n[0]}, 2'b10);
		cyc(1);
		chk(pin_o[0], 0);
		{latch, cmp0, cmp1} = {32'hffff_ffff, 2'b00};
	endtask
	// Open drain everywhere, so only SDA pulling low shows where it landed
	task t_spi;
		pp = '0;
		sda = 1;
		pin = 32'hffff_ffd5;
		for (int w = 0; w < 2; w++)
		begin
			four = w[0];
			cfg(8'h03, 8'h00);
			chk(oe_n[4:3], w ? 2'b01 : 2'b10);
			chk({pin_o[2:0], sck_in, miso_in, mosi_in, nss_in, sda_in, scl_in}, w ? 9'h02a : 9'h02d);
		end
		pp = '1;
		sda = 0;
		pin = '1;
	endtask
	// Mid-run reset drops every route and driver and clears both enables, all at once
	task t_reset;
		tx = 0;
		pin = 32'hffff_fff9;
		cfg(8'h04, 8'h04);
		chk({pin_o[0], rx, i0}, 3'b000);
		nrst = 0;
		#1;
		chk({pin_o[0], rx, i0, rdata}, {3'b111, 8'h00});
		chk(oe_n, 32'hffff_ffff);
		cyc(2);
		nrst = 1;
		cyc(2);
		chk({pin_o[0], rx, i0}, 3'b111);
		rd8(8'he1, 8'h00);
		rd8(8'he2, 8'h00);
		{tx, pin} = {1'b1, 32'hffff_ffff};
	endtask
	task end_sim;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		cyc(8);
		nrst = 1;
		cyc(1);
		t_regs;
		t_codes;
		t_example;
		t_inputs;
		t_outs;
		t_spi;
		t_reset;
		end_sim;
	end
	// Hang guard
	initial
	begin
		#200000;
		mismatches++;
		end_sim;
	end
endmodule // tb_xbc_crossbar
